//--- dv/tb_top.sv
// Purpose: Self-checking bench for the flash configuration/control register block
// Assumes: Wishbone acks one cycle after the strobe; reads return lane 0 only
// Notes:   Bus reads are checked by a monitor that pops expected data off a queue
`timescale 1ns/1ps
module tb_top;
	logic                      sys_clk = 1'b0;
	logic                      rst_n = 1'b0;
	logic                      wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
	logic [7:0]                wbAdr = 8'h00;
	logic [3:0]                wbSel = 4'h0;
	logic [31:0]               wbDatW = 32'h0, wbDatR;
	logic                      wbAck, cmdLaunch, erasePause, eraseAllBusy, irq;
	logic                      pin = 1'b0, cmdDoneIn = 1'b0, readClashIn = 1'b0;
	logic                      secBusy = 1'b0, resumed = 1'b0, stepDone = 1'b0;
	logic [1:0]                securityField;
	flash_cfg_pkg::step_req_s  stepReq;
	int                        errTotal = 0, nTests = 0, launchCnt = 0;
	logic [31:0]               expQ[$], mskQ[$];

	always #12.5 sys_clk = ~sys_clk;

	flash_config_control_reg u_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
		.wb_dat_o(wbDatR), .wb_ack_o(wbAck), .eraseAllReqPin(pin), .cmdDoneIn(cmdDoneIn),
		.readClashIn(readClashIn), .sectorEraseBusy(secBusy), .eraseResumed(resumed),
		.stepDone(stepDone), .cmdLaunch(cmdLaunch), .stepReq(stepReq),
		.erasePause(erasePause), .eraseAllBusy(eraseAllBusy),
		.securityField(securityField), .irq(irq)
	);

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			errTotal++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Every ack consumes the oldest expectation; writes expect zero data
	always @(posedge sys_clk) begin
		if (wbAck === 1'b1) begin
			if (expQ.size() == 0)
				chk("spurious ack", 32'h1, 32'h0);
			else
				chk("wb_dat_o", wbDatR & mskQ.pop_front(), expQ.pop_front());
		end
		if (cmdLaunch === 1'b1)
			launchCnt++;
	end

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [31:0] e, input logic [31:0] m);
		int n;
		n = 0;
		@(posedge sys_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDatW <= d;
		wbSel <= s;
		expQ.push_back(e);
		mskQ.push_back(m);
		do begin
			@(posedge sys_clk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
		if (wbAck !== 1'b1) begin
			errTotal++;
			giveVerdict();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hF, 32'h0, 32'hFFFFFFFF);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		wb(1'b0, a, 32'h0, 4'hF, e, m);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// Single-cycle pulse on one of the engine-side event inputs
	task automatic pulse(input int k);
		@(posedge sys_clk);
		case (k)
			0: cmdDoneIn <= 1'b1;
			1: readClashIn <= 1'b1;
			2: stepDone <= 1'b1;
			default: resumed <= 1'b1;
		endcase
		@(posedge sys_clk);
		{cmdDoneIn, readClashIn, stepDone, resumed} <= 4'h0;
	endtask

	task automatic waitGo();
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (stepReq.go !== 1'b1 && n < 40);
		if (stepReq.go !== 1'b1) begin
			errTotal++;
			giveVerdict();
		end
	endtask

	initial begin
		int          r;
		int          n;
		logic [31:0] d;
		r = $urandom(41810);
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		chk("securityField", securityField, 32'h3);
		chk("eraseAllBusy", eraseAllBusy, 32'h0);
		idle(4);
		rd(8'h00, 32'h80, 32'hFF);
		rd(8'h08, 32'h3, 32'hFFFFFFFF);
		repeat (4) begin
			d = $urandom;
			wr(8'h04, d);
			rd(8'h04, {24'h0, d[7:6], 6'h0}, 32'hFFFFFFFF);
		end
		wr(8'h04, 32'h0);
		wb(1'b1, 8'h04, 32'hC0, 4'h0, 32'h0, 32'hFFFFFFFF);
		rd(8'h04, 32'h0, 32'hFFFFFFFF);
		wr(8'h3C, 32'hFF);
		rd(8'h3C, 32'h0, 32'hFFFFFFFF);
		wr(8'h04, 32'h80);
		idle(3);
		chk("irq", irq, 32'h1);
		wr(8'h04, 32'h0);
		idle(3);
		chk("irq", irq, 32'h0);
		wr(8'h04, 32'h80);
		n = launchCnt;
		wr(8'h00, 32'h80);
		idle(3);
		chk("cmdLaunch", launchCnt - n, 32'h1);
		rd(8'h00, 32'h0, 32'hFF);
		chk("irq", irq, 32'h0);
		// Request during a running command must be dropped, not remembered
		pin <= 1'b1;
		idle(8);
		chk("eraseAllBusy", eraseAllBusy, 32'h0);
		pin <= 1'b0;
		idle(6);
		pulse(0);
		idle(3);
		rd(8'h00, 32'h80, 32'hFF);
		chk("irq", irq, 32'h1);
		wr(8'h04, 32'h40);
		pulse(1);
		idle(3);
		chk("irq", irq, 32'h1);
		rd(8'h00, 32'hC0, 32'hFF);
		wr(8'h00, 32'h0);
		rd(8'h00, 32'hC0, 32'hFF);
		wr(8'h00, 32'h40);
		rd(8'h00, 32'h80, 32'hFF);
		idle(2);
		chk("irq", irq, 32'h0);
		wr(8'h04, 32'h10);
		idle(2);
		chk("erasePause", erasePause, 32'h0);
		secBusy <= 1'b1;
		wr(8'h04, 32'h10);
		idle(2);
		chk("erasePause", erasePause, 32'h1);
		pulse(3);
		idle(2);
		chk("erasePause", erasePause, 32'h0);
		wr(8'h04, 32'h10);
		idle(2);
		secBusy <= 1'b0;
		idle(3);
		chk("erasePause", erasePause, 32'h0);
		wr(8'h04, 32'h0);
		wr(8'h10, 32'h04);
		rd(8'h10, 32'h04, 32'hFF);
		rd(8'h0C, 32'h3, 32'hFF);
		pin <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			waitGo();
			chk("eraseAllBusy", eraseAllBusy, 32'h1);
			chk("stepReq.code", stepReq.code, k);
			if (k == 0) begin
				wr(8'h04, 32'h0);
				rd(8'h04, 32'h20, 32'hFF);
				rd(8'h00, 32'h0, 32'hFF);
			end
			idle(2);
			pulse(2);
		end
		n = 0;
		while (eraseAllBusy !== 1'b0 && n < 10) begin
			@(posedge sys_clk);
			n++;
		end
		chk("busy wait", n < 10, 32'h1);
		idle(2);
		chk("securityField", securityField, 32'h2);
		chk("irq", irq, 32'h1);
		rd(8'h0C, 32'h4, 32'hFF);
		idle(3);
		chk("irq", irq, 32'h0);
		rd(8'h00, 32'h80, 32'hFF);
		rd(8'h08, 32'h2, 32'hFFFFFFFF);
		pin <= 1'b0;
		idle(2);
		giveVerdict();
	end
endmodule

//--- verilog/flash_cfg_pkg.sv
// Purpose: Shared constants and types for the flash configuration/control register block
// Assumes: Classic Wishbone slave with 32-bit data, one register per aligned word
// Notes:   Register index times four gives the byte address
package flash_cfg_pkg;

	// Register indices and bus address width
	localparam int unsigned   ADDR_W           = 8;
	localparam logic [5:0]    IDX_STATUS       = 6'h00;
	localparam logic [5:0]    IDX_CONFIG       = 6'h01;
	localparam logic [5:0]    IDX_SECURITY     = 6'h02;
	localparam logic [5:0]    IDX_EVT_STATUS   = 6'h03;
	localparam logic [5:0]    IDX_EVT_MASK     = 6'h04;

	// flash_status_reg fields
	localparam int unsigned   ST_CMD_DONE      = 7;
	localparam int unsigned   ST_READ_CLASH    = 6;

	// flash_config_control fields
	localparam int unsigned   CF_CMD_IRQ_EN    = 7;
	localparam int unsigned   CF_CLASH_IRQ_EN  = 6;
	localparam int unsigned   CF_ERASE_ALL     = 5;
	localparam int unsigned   CF_ERASE_PAUSE   = 4;
	localparam logic [3:0]    CF_RESERVED      = 4'h0;
	localparam logic [7:0]    CF_RESET         = 8'h00;

	// Event status / mask fields
	localparam int unsigned   EV_W             = 3;
	localparam int unsigned   EV_CMD_DONE      = 0;
	localparam int unsigned   EV_READ_CLASH    = 1;
	localparam int unsigned   EV_ERASE_ALL     = 2;
	localparam logic [2:0]    EV_RESET         = 3'h0;

	// security_field encodings; values are arbitrary
	localparam logic [1:0]    SEC_SECURE       = 2'h3;
	localparam logic [1:0]    SEC_UNSECURE     = 2'h2;

	// Steps handed to the command engine during an erase-all
	typedef enum logic [1:0] {
		STEP_ERASE_BLOCKS,
		STEP_VERIFY_ERASED,
		STEP_PROGRAM_SEC_BYTE
	} step_code_e;

	typedef enum logic [2:0] {
		EA_IDLE,
		EA_ERASE,
		EA_VERIFY,
		EA_PROGRAM,
		EA_RELEASE
	} erase_all_state_e;

	typedef struct packed {
		logic       go;
		step_code_e code;
	} step_req_s;

endpackage

//--- verilog/flash_config_control_reg.sv
// Purpose: Configuration/control register of a flash controller with erase-all sequencer
// Assumes: Command engine runs the actual flash operations and reports by pulses
// Notes:   Wishbone answers every access with ack in the cycle after the strobe
`timescale 1ns/1ps

module flash_config_control_reg (
	input  wire logic                                sys_clk,
	input  wire logic                                rst_n,
	input  wire logic                                wb_cyc_i,
	input  wire logic                                wb_stb_i,
	input  wire logic                                wb_we_i,
	input  wire logic [flash_cfg_pkg::ADDR_W-1:0]    wb_adr_i,
	input  wire logic [3:0]                          wb_sel_i,
	input  wire logic [31:0]                         wb_dat_i,
	output logic      [31:0]                         wb_dat_o,
	output logic                                     wb_ack_o,
	input  wire logic                                eraseAllReqPin,
	input  wire logic                                cmdDoneIn,
	input  wire logic                                readClashIn,
	input  wire logic                                sectorEraseBusy,
	input  wire logic                                eraseResumed,
	input  wire logic                                stepDone,
	output logic                                     cmdLaunch,
	output flash_cfg_pkg::step_req_s                 stepReq,
	output logic                                     erasePause,
	output logic                                     eraseAllBusy,
	output logic      [1:0]                          securityField,
	output logic                                     irq
);

	typedef struct packed {
		logic [2:0]                            sync;
		logic                                  reqLevel;
		logic                                  initPending;
		logic                                  cmdDone;
		logic                                  readClash;
		logic                                  cmdIrqEn;
		logic                                  clashIrqEn;
		logic                                  eraseAll;
		logic                                  pause;
		logic [1:0]                            secField;
		logic [flash_cfg_pkg::EV_W-1:0]        evStatus;
		logic [flash_cfg_pkg::EV_W-1:0]        evMask;
		flash_cfg_pkg::erase_all_state_e       eaState;
		flash_cfg_pkg::step_req_s              step;
		logic                                  launch;
		logic                                  ack;
		logic [31:0]                           rdata;
		logic                                  irq;
	} state_s;

	state_s q;
	state_s d;

	logic                                      access;
	logic                                      wrLane0;
	logic                                      rdAcc;
	logic [5:0]                                regIdx;
	logic                                      reqRise;
	logic [7:0]                                wByte;

	function automatic logic [5:0] reg_index(input logic [flash_cfg_pkg::ADDR_W-1:0] a);
		reg_index = a[7:2];
	endfunction

	function automatic logic [7:0] status_byte(input state_s s);
		status_byte = 8'h00;
		status_byte[flash_cfg_pkg::ST_CMD_DONE] = s.cmdDone;
		status_byte[flash_cfg_pkg::ST_READ_CLASH] = s.readClash;
	endfunction

	function automatic logic [7:0] config_byte(input state_s s);
		config_byte = {s.cmdIrqEn, s.clashIrqEn, s.eraseAll, s.pause, flash_cfg_pkg::CF_RESERVED};
	endfunction

	always_comb begin
		d = q;
		d.launch = 1'b0;
		d.step.go = 1'b0;
		regIdx = reg_index(wb_adr_i);
		access = wb_cyc_i & wb_stb_i & ~q.ack;
		wrLane0 = access & wb_we_i & wb_sel_i[0];
		rdAcc = access & ~wb_we_i;
		wByte = wb_dat_i[7:0];

		// Pin filter: a change counts once the last two stages agree
		d.sync = {q.sync[1:0], eraseAllReqPin};
		reqRise = 1'b0;
		if (q.sync[2] == q.sync[1]) begin
			d.reqLevel = q.sync[1];
			reqRise = q.sync[1] & ~q.reqLevel;
		end

		// Done flag comes up once after reset, like the end of init
		if (q.initPending) begin
			d.initPending = 1'b0;
			d.cmdDone = 1'b1;
		end

		// Bus access
		d.ack = access;
		d.rdata = 32'h0000_0000;
		if (rdAcc) begin
			case (regIdx)
				flash_cfg_pkg::IDX_STATUS: begin
					d.rdata[7:0] = status_byte(q);
				end
				flash_cfg_pkg::IDX_CONFIG: begin
					d.rdata[7:0] = config_byte(q);
				end
				flash_cfg_pkg::IDX_SECURITY: begin
					d.rdata[1:0] = q.secField;
				end
				flash_cfg_pkg::IDX_EVT_STATUS: begin
					d.rdata[flash_cfg_pkg::EV_W-1:0] = q.evStatus;
					d.evStatus = flash_cfg_pkg::EV_RESET;
				end
				flash_cfg_pkg::IDX_EVT_MASK: begin
					d.rdata[flash_cfg_pkg::EV_W-1:0] = q.evMask;
				end
				default: begin
					d.rdata = 32'h0000_0000;
				end
			endcase
		end

		if (wrLane0) begin
			case (regIdx)
				flash_cfg_pkg::IDX_STATUS: begin
					if (wByte[flash_cfg_pkg::ST_CMD_DONE] && q.cmdDone && !q.eraseAll) begin
						d.cmdDone = 1'b0;
						d.launch = 1'b1;
					end
					if (wByte[flash_cfg_pkg::ST_READ_CLASH]) begin
						d.readClash = 1'b0;
					end
				end
				flash_cfg_pkg::IDX_CONFIG: begin
					// erase-all bit not written here; low bits dropped
					d.cmdIrqEn = wByte[flash_cfg_pkg::CF_CMD_IRQ_EN];
					d.clashIrqEn = wByte[flash_cfg_pkg::CF_CLASH_IRQ_EN];
					// pause only during a sector erase
					if (sectorEraseBusy) begin
						d.pause = wByte[flash_cfg_pkg::CF_ERASE_PAUSE];
					end
				end
				flash_cfg_pkg::IDX_EVT_MASK: begin
					d.evMask = wByte[flash_cfg_pkg::EV_W-1:0];
				end
				default: begin
					d.evMask = d.evMask;
				end
			endcase
		end

		// pause drops on resume or when the erase ends
		if (eraseResumed || !sectorEraseBusy) begin
			d.pause = 1'b0;
		end

		// Hardware sets follow the clears so a coincident event is kept
		// completion and read-clash sets
		if (cmdDoneIn && !q.eraseAll) begin
			d.cmdDone = 1'b1;
			d.evStatus[flash_cfg_pkg::EV_CMD_DONE] = 1'b1;
		end
		if (readClashIn) begin
			d.readClash = 1'b1;
			d.evStatus[flash_cfg_pkg::EV_READ_CLASH] = 1'b1;
		end

		case (q.eaState)
			flash_cfg_pkg::EA_IDLE: begin
				if (reqRise && q.cmdDone && !d.launch) begin
					d.eraseAll = 1'b1;
					d.cmdDone = 1'b0;
					d.eaState = flash_cfg_pkg::EA_ERASE;
					d.step = '{go: 1'b1, code: flash_cfg_pkg::STEP_ERASE_BLOCKS};
				end
			end
			flash_cfg_pkg::EA_ERASE: begin
				if (stepDone) begin
					d.eaState = flash_cfg_pkg::EA_VERIFY;
					d.step = '{go: 1'b1, code: flash_cfg_pkg::STEP_VERIFY_ERASED};
				end
			end
			flash_cfg_pkg::EA_VERIFY: begin
				if (stepDone) begin
					d.eaState = flash_cfg_pkg::EA_PROGRAM;
					d.step = '{go: 1'b1, code: flash_cfg_pkg::STEP_PROGRAM_SEC_BYTE};
				end
			end
			flash_cfg_pkg::EA_PROGRAM: begin
				if (stepDone) begin
					d.eaState = flash_cfg_pkg::EA_RELEASE;
				end
			end
			flash_cfg_pkg::EA_RELEASE: begin
				d.secField = flash_cfg_pkg::SEC_UNSECURE;
				d.eraseAll = 1'b0;
				d.cmdDone = 1'b1;
				d.evStatus[flash_cfg_pkg::EV_ERASE_ALL] = 1'b1;
				d.eaState = flash_cfg_pkg::EA_IDLE;
			end
			default: begin
				d.eaState = flash_cfg_pkg::EA_IDLE;
			end
		endcase

		d.irq = (d.cmdIrqEn & d.cmdDone) | (d.clashIrqEn & d.readClash)
			| (|(d.evStatus & d.evMask));
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			q <= '{
				sync:        3'h0,
				reqLevel:    1'b0,
				initPending: 1'b1,
				cmdDone:     1'b0,
				readClash:   1'b0,
				cmdIrqEn:    flash_cfg_pkg::CF_RESET[flash_cfg_pkg::CF_CMD_IRQ_EN],
				clashIrqEn:  flash_cfg_pkg::CF_RESET[flash_cfg_pkg::CF_CLASH_IRQ_EN],
				eraseAll:    flash_cfg_pkg::CF_RESET[flash_cfg_pkg::CF_ERASE_ALL],
				pause:       flash_cfg_pkg::CF_RESET[flash_cfg_pkg::CF_ERASE_PAUSE],
				secField:    flash_cfg_pkg::SEC_SECURE,
				evStatus:    flash_cfg_pkg::EV_RESET,
				evMask:      flash_cfg_pkg::EV_RESET,
				eaState:     flash_cfg_pkg::EA_IDLE,
				step:        '{go: 1'b0, code: flash_cfg_pkg::STEP_ERASE_BLOCKS},
				launch:      1'b0,
				ack:         1'b0,
				rdata:       32'h0000_0000,
				irq:         1'b0
			};
		end else begin
			q <= d;
		end
	end

	assign wb_dat_o = q.rdata;
	assign wb_ack_o = q.ack;
	assign cmdLaunch = q.launch;
	assign stepReq = q.step;
	assign erasePause = q.pause;
	assign eraseAllBusy = q.eraseAll;
	assign securityField = q.secField;
	assign irq = q.irq;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_erase_done;
		q.eaState == flash_cfg_pkg::EA_ERASE && stepDone;
	endsequence

	sequence s_verify_go;
		q.eaState == flash_cfg_pkg::EA_VERIFY && q.step.go
			&& q.step.code == flash_cfg_pkg::STEP_VERIFY_ERASED;
	endsequence

	sequence s_verify_done;
		q.eaState == flash_cfg_pkg::EA_VERIFY && stepDone;
	endsequence

	sequence s_program_go;
		q.eaState == flash_cfg_pkg::EA_PROGRAM && q.step.go
			&& q.step.code == flash_cfg_pkg::STEP_PROGRAM_SEC_BYTE;
	endsequence

	AST_CMD_IRQ: assert property ((q.cmdIrqEn && q.cmdDone) |-> irq)
		else $error("command-complete interrupt missing");

	AST_IRQ_QUIET: assert property ((!q.cmdIrqEn && !q.clashIrqEn && q.evMask == 3'h0) |-> !irq)
		else $error("interrupt raised with all enables off");

	AST_CLASH_IRQ: assert property ((q.clashIrqEn && q.readClash) |-> irq)
		else $error("read-clash interrupt missing");

	AST_EA_NO_WRITE: assert property ((wrLane0 && regIdx == flash_cfg_pkg::IDX_CONFIG
		&& !q.eraseAll && !reqRise) |=> !q.eraseAll)
		else $error("erase-all bit changed by a write");

	AST_EA_SET_COND: assert property ($rose(q.eraseAll) |-> $past(q.cmdDone) && $past(reqRise))
		else $error("erase-all taken without command-complete");

	AST_EA_ORDER: assert property ((s_erase_done |=> s_verify_go)
		and (s_verify_done |=> s_program_go))
		else $error("erase-all steps out of order");

	AST_SEC_HOLD: assert property ($changed(q.secField)
		|-> $past(q.eaState) == flash_cfg_pkg::EA_RELEASE)
		else $error("security field changed outside the erase-all release");

	AST_EA_FINISH: assert property ((q.eaState == flash_cfg_pkg::EA_RELEASE) |=>
		(!q.eraseAll && q.cmdDone && q.eaState == flash_cfg_pkg::EA_IDLE
		&& q.secField == flash_cfg_pkg::SEC_UNSECURE))
		else $error("erase-all did not finish cleanly");

	AST_PAUSE_SET: assert property ((wrLane0 && regIdx == flash_cfg_pkg::IDX_CONFIG
		&& sectorEraseBusy && wByte[flash_cfg_pkg::CF_ERASE_PAUSE] && !eraseResumed)
		|=> erasePause)
		else $error("erase pause not taken");

	AST_PAUSE_IDLE: assert property (!sectorEraseBusy |=> !erasePause)
		else $error("erase pause held without a sector erase");

	AST_RSV_ZERO: assert property ((wb_ack_o && $past(regIdx) == flash_cfg_pkg::IDX_CONFIG
		&& !$past(wb_we_i)) |-> wb_dat_o[3:0] == 4'h0)
		else $error("reserved config bits read nonzero");

	AST_LAUNCH: assert property ((wrLane0 && regIdx == flash_cfg_pkg::IDX_STATUS && q.cmdDone
		&& !q.eraseAll && wByte[flash_cfg_pkg::ST_CMD_DONE] && !cmdDoneIn) |=> cmdLaunch && !q.cmdDone)
		else $error("command launch failed");

	AST_CLASH_SET: assert property (readClashIn |=> q.readClash
		##1 (q.readClash || $past(wrLane0)))
		else $error("read clash lost");

	AST_CLASH_CLEAR: assert property ((wrLane0 && regIdx == flash_cfg_pkg::IDX_STATUS
		&& wByte[flash_cfg_pkg::ST_READ_CLASH] && !readClashIn) |=> !q.readClash)
		else $error("read clash not cleared by a write of one");

	AST_ACK_PULSE: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single pulse");

endmodule
